// [common/sss_pkg.sv]
package sss_pkg;
   // Clock rate of the sequencer.
   localparam int unsigned CLK_HZ = 10_000_000;

   // External timebase counts, in timebase clocks.
   localparam logic [15:0] EXT_FIRST_CLKS = 16'h5000;
   localparam logic [15:0] EXT_NORMAL_CLKS = 16'h1400;
   localparam logic [15:0] EXT_RESET_CLKS = 16'h0281;

   // Internal timebase times in microseconds.
   localparam longint unsigned WD_LONG_US = 64'd2_700_000;
   localparam longint unsigned WD_SHORT_US = 64'd170_000;
   localparam longint unsigned RST_PULSE_US = 64'd85_000;
   localparam longint unsigned PU_RESET_US = 64'd100_000;
   localparam longint unsigned CE_HOLD_US = 64'd5;
   localparam longint unsigned CF_DELAY_US = 64'd7;

   // Derived cycle counts: holds and delays round down.
   localparam longint unsigned WD_LONG_CYC = WD_LONG_US * CLK_HZ / 1_000_000;
   localparam longint unsigned WD_SHORT_CYC = WD_SHORT_US * CLK_HZ / 1_000_000;
   localparam longint unsigned RST_PULSE_CYC = RST_PULSE_US * CLK_HZ / 1_000_000;
   localparam longint unsigned PU_RESET_CYC = PU_RESET_US * CLK_HZ / 1_000_000;
   localparam logic [7:0] CE_HOLD_CYC = 8'(CE_HOLD_US * CLK_HZ / 1_000_000);
   localparam logic [7:0] CF_DELAY_CYC = 8'(CF_DELAY_US * CLK_HZ / 1_000_000);

   // Asynchronous supply comparator flags.
   typedef struct packed {
      logic below_reset_trip;
      logic below_sense_trip;
      logic below_battery;
      logic battery_present;
   } sss_supply_t;

   typedef enum logic [1:0] {
      SSS_PASS   = 2'b00,
      SSS_HOLD   = 2'b01,
      SSS_DELAY  = 2'b10,
      SSS_PROT   = 2'b11
   } sss_ce_state_t;
endpackage

// [rtl/sss_sync.sv]
`timescale 1ns/1ps
module sss_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             clk_sys_i,
   input  wire logic             sys_rst_i,
   // Asynchronous in, synchronised out.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         stage1 <= '0;
         stage2 <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
      end
   end

   assign sync_o = stage2;
endmodule // sss_sync

// [rtl/sss_supervisor.sv]
`timescale 1ns/1ps
// Functional notes
// - External clock with select low: first watchdog period 20480 clocks, later 5120, reset pulse 641.
// - Select high uses the internal timebase: 2.7 s periods, 85 ms reset, 170 ms later periods if input low.
// - With good supply the SRAM enable output follows the enable input.
// - An enable active at supply failure is frozen until it returns high or the hold limit expires.
// - An enable inactive at supply failure is forced inactive within a bounded delay and kept so.
// - Write protection starts when supply drops below the reset trip, together with reset.
// - After battery attach the switched SRAM supply stays off until main supply has been seen once.
// - Once main supply was applied the seal stays broken until the battery is removed and reattached.
// - On power-down the supply switch flag rises when supply decays to battery voltage.
// - On power-up the supply switch flag falls as soon as supply exceeds battery voltage.
// - Power-down raises the interrupt first at the sense trip, then both resets at the reset trip.
// - On power-up reset is held for the full power-up reset time regardless of the interrupt.
// - After power-up a new sense trip raises the interrupt and a missing kick causes a watchdog reset.
// - A falling kick edge restarts the watchdog and an open kick input disables it.
module sss_supervisor #(
   parameter longint unsigned WD_LONG   = sss_pkg::WD_LONG_CYC,
   parameter longint unsigned WD_SHORT  = sss_pkg::WD_SHORT_CYC,
   parameter longint unsigned RST_PULSE = sss_pkg::RST_PULSE_CYC,
   parameter longint unsigned PU_RESET  = sss_pkg::PU_RESET_CYC
) (
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              sys_rst_i,
   // Supply comparator flags, asynchronous.
   input  wire sss_pkg::sss_supply_t supply_i,
   // Timebase straps and external clock.
   input  wire logic              timebase_input_i,
   input  wire logic              timebase_select_i,
   // Processor side.
   input  wire logic              watchdog_kick_n_i,
   input  wire logic              watchdog_kick_open_i,
   output logic                   reset_o,
   output logic                   reset_n_o,
   output logic                   interrupt_n_o,
   output logic                   watchdog_timeout_flag_n_o,
   output logic                   reset_trip_level_n_o,
   // SRAM side.
   input  wire logic              sram_enable_in_n_i,
   output logic                   sram_enable_out_n_o,
   output logic                   switched_sram_supply_o,
   output logic                   supply_switch_flag_o
);
   localparam int unsigned NSYNC = 8;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] syn;
   logic below_rst, below_sense, below_bat, bat_ok, tb_in, tb_sel, kick_n, kick_open;
   logic ce_in_n;

   assign raw = {supply_i, timebase_input_i, timebase_select_i, watchdog_kick_n_i, watchdog_kick_open_i};

   sss_sync #(.WIDTH(NSYNC)) u_sync (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (raw),
      .sync_o    (syn)
   );

   assign {below_rst, below_sense, below_bat, bat_ok} = syn[7:4];
   assign {tb_in, tb_sel, kick_n, kick_open} = syn[3:0];
   // The enable input is a bus signal on this clock, so it is not delayed.
   assign ce_in_n = sram_enable_in_n_i;

   // Timebase edge, kick edge and timebase mode.
   logic tb_prev, kick_prev;
   logic tb_tick, kick_fall, ext_mode;
   assign ext_mode = !tb_sel;
   assign tb_tick = ext_mode ? (tb_in && !tb_prev) : 1'b1;
   assign kick_fall = kick_prev && !kick_n && !kick_open;

   // Reset and watchdog state.
   logic [31:0] cnt, next_cnt;
   logic        in_reset, next_in_reset;
   logic        first_per, next_first_per;
   logic        wd_flag, next_wd_flag;
   logic        pu_phase, next_pu_phase;
   logic [31:0] period_len, pulse_len;

   always_comb begin
      if (ext_mode) begin
         period_len = first_per ? 32'(sss_pkg::EXT_FIRST_CLKS) : 32'(sss_pkg::EXT_NORMAL_CLKS);
         pulse_len = 32'(sss_pkg::EXT_RESET_CLKS);
      end else begin
         period_len = (!first_per && !tb_in) ? 32'(WD_SHORT) : 32'(WD_LONG);
         pulse_len = 32'(RST_PULSE);
      end
   end

   always_comb begin
      next_cnt = cnt;
      next_in_reset = in_reset;
      next_first_per = first_per;
      next_wd_flag = wd_flag;
      next_pu_phase = pu_phase;
      if (below_rst) begin
         next_in_reset = 1'b1;
         next_pu_phase = 1'b1;
         next_wd_flag = 1'b1;
         next_first_per = 1'b1;
         next_cnt = '0;
      end else if (in_reset) begin
         // Power-up reset counts system cycles; watchdog reset counts timebase ticks.
         if (pu_phase) begin
            next_cnt = cnt + 32'h1;
            if (cnt + 32'h1 >= 32'(PU_RESET)) begin
               next_in_reset = 1'b0;
               next_pu_phase = 1'b0;
               next_cnt = '0;
            end
         end else if (tb_tick) begin
            next_cnt = cnt + 32'h1;
            if (cnt + 32'h1 >= pulse_len) begin
               next_in_reset = 1'b0;
               next_cnt = '0;
            end
         end
      end else if (kick_open) begin
         next_cnt = '0;
         next_wd_flag = 1'b0;
      end else if (tb_tick && (cnt + 32'h1 >= period_len)) begin
         // A kick that lands on the expiring tick is too late, so the timeout wins.
         next_in_reset = 1'b1;
         next_wd_flag = 1'b1;
         next_first_per = 1'b0;
         next_cnt = '0;
      end else if (kick_fall) begin
         next_cnt = '0;
         next_wd_flag = 1'b0;
         next_first_per = 1'b0;
      end else if (tb_tick) begin
         next_cnt = cnt + 32'h1;
      end
   end

   // SRAM enable gating.
   sss_pkg::sss_ce_state_t ce_st, next_ce_st;
   logic [7:0] ce_cnt, next_ce_cnt;
   logic       ce_out_n, next_ce_out_n;

   always_comb begin
      next_ce_st = ce_st;
      next_ce_cnt = ce_cnt;
      next_ce_out_n = ce_out_n;
      unique case (ce_st)
         sss_pkg::SSS_PASS: begin
            next_ce_out_n = ce_in_n;
            if (below_rst) begin
               next_ce_cnt = '0;
               if (!ce_out_n) begin
                  next_ce_st = sss_pkg::SSS_HOLD;
                  next_ce_out_n = 1'b0;
               end else begin
                  next_ce_st = sss_pkg::SSS_DELAY;
                  next_ce_out_n = 1'b1;
               end
            end
         end
         sss_pkg::SSS_HOLD: begin
            next_ce_cnt = ce_cnt + 8'h01;
            if (ce_in_n || (ce_cnt + 8'h01 >= sss_pkg::CE_HOLD_CYC)) begin
               next_ce_st = sss_pkg::SSS_PROT;
               next_ce_out_n = 1'b1;
            end
         end
         sss_pkg::SSS_DELAY: begin
            next_ce_out_n = 1'b1;
            next_ce_cnt = ce_cnt + 8'h01;
            if (ce_cnt + 8'h01 >= sss_pkg::CF_DELAY_CYC) begin
               next_ce_st = sss_pkg::SSS_PROT;
            end
         end
         sss_pkg::SSS_PROT: begin
            next_ce_out_n = 1'b1;
            if (!below_rst) begin
               next_ce_st = sss_pkg::SSS_PASS;
            end
         end
      endcase
   end

   // Freshness seal and interrupt.
   logic sealed, next_sealed;
   logic irq, next_irq;

   always_comb begin
      next_sealed = sealed;
      if (!bat_ok) begin
         next_sealed = 1'b1;
      end else if (!below_bat) begin
         next_sealed = 1'b0;
      end
      // Sense trips are masked while the supply is below the reset trip.
      next_irq = below_sense && !below_rst;
      if (below_sense && irq) begin
         next_irq = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tb_prev <= 1'b0;
         // Matches the synchroniser's reset value, so no false edge follows reset.
         kick_prev <= 1'b0;
         cnt <= '0;
         in_reset <= 1'b1;
         first_per <= 1'b1;
         wd_flag <= 1'b1;
         pu_phase <= 1'b1;
         ce_st <= sss_pkg::SSS_PROT;
         ce_cnt <= '0;
         ce_out_n <= 1'b1;
         sealed <= 1'b1;
         irq <= 1'b0;
      end else begin
         tb_prev <= tb_in;
         kick_prev <= kick_n;
         cnt <= next_cnt;
         in_reset <= next_in_reset;
         first_per <= next_first_per;
         wd_flag <= next_wd_flag;
         pu_phase <= next_pu_phase;
         ce_st <= next_ce_st;
         ce_cnt <= next_ce_cnt;
         ce_out_n <= next_ce_out_n;
         sealed <= next_sealed;
         irq <= next_irq;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         reset_o <= 1'b1;
         reset_n_o <= 1'b0;
         reset_trip_level_n_o <= 1'b0;
         supply_switch_flag_o <= 1'b1;
         switched_sram_supply_o <= 1'b0;
      end else begin
         reset_o <= next_in_reset;
         reset_n_o <= !next_in_reset;
         reset_trip_level_n_o <= !below_rst;
         supply_switch_flag_o <= below_bat;
         switched_sram_supply_o <= bat_ok && !next_sealed;
      end
   end

   assign interrupt_n_o = !irq;
   assign watchdog_timeout_flag_n_o = !wd_flag;
   assign sram_enable_out_n_o = ce_out_n;
endmodule // sss_supervisor

// [sim/sss_supervisor_asserts.sv]
`timescale 1ns/1ps
module sss_chk #(
   parameter longint unsigned PU_RESET = 60
) (
   // Clock and reset.
   input wire logic                 clk_sys_i,
   input wire logic                 sys_rst_i,
   // Watched ports.
   input wire sss_pkg::sss_supply_t supply_i,
   input wire logic                 watchdog_kick_open_i,
   input wire logic                 sram_enable_in_n_i,
   input wire logic                 reset_o,
   input wire logic                 reset_n_o,
   input wire logic                 interrupt_n_o,
   input wire logic                 watchdog_timeout_flag_n_o,
   input wire logic                 reset_trip_level_n_o,
   input wire logic                 sram_enable_out_n_o,
   input wire logic                 supply_switch_flag_o
);
   logic [31:0] good_cnt;
   logic [31:0] bad_cnt;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // Cycles spent on each side of the reset trip, saturating.
   always_ff @(posedge clk_sys_i) begin
      good_cnt <= (sys_rst_i || supply_i.below_reset_trip) ? 32'h0 : good_cnt + 32'(good_cnt != 32'hFFFFFFFF);
      bad_cnt  <= (sys_rst_i || !supply_i.below_reset_trip) ? 32'h0 : bad_cnt + 32'(bad_cnt != 32'hFFFFFFFF);
   end
   chk_reset_pair: assert property (reset_o == !reset_n_o)
      else $error("reset outputs disagree");
   chk_pu_hold: assert property (good_cnt >= 4 && good_cnt < PU_RESET |-> reset_o)
      else $error("power-up reset ended early");
   chk_pu_end: assert property (good_cnt == PU_RESET + 8 |-> !reset_o)
      else $error("power-up reset too long");
   chk_ce_pass: assert property (!supply_i.below_reset_trip [*8] |-> sram_enable_out_n_o == $past(sram_enable_in_n_i))
      else $error("enable does not follow");
   chk_ce_protect: assert property (bad_cnt > 80 |-> sram_enable_out_n_o)
      else $error("enable not protected");
   chk_trip_reset: assert property (supply_i.below_reset_trip [*5] |-> reset_o && !reset_trip_level_n_o && !watchdog_timeout_flag_n_o)
      else $error("trip outputs idle");
   chk_int_raise: assert property ((supply_i.below_sense_trip && good_cnt > 8) [*5] |-> !interrupt_n_o)
      else $error("interrupt missing");
   chk_int_clear: assert property (!supply_i.below_sense_trip [*5] |-> interrupt_n_o)
      else $error("interrupt stuck");
   chk_flag_on: assert property (supply_i.below_battery [*5] |-> supply_switch_flag_o)
      else $error("switch flag missing");
   chk_flag_off: assert property (!supply_i.below_battery [*5] |-> !supply_switch_flag_o)
      else $error("switch flag stuck");
   chk_wd_open: assert property ((watchdog_kick_open_i && good_cnt > 4) [*5] |-> watchdog_timeout_flag_n_o)
      else $error("open kick keeps flag");
endmodule // sss_chk
bind sss_supervisor sss_chk #(.PU_RESET(PU_RESET)) u_chk (
   .clk_sys_i, .sys_rst_i, .supply_i, .watchdog_kick_open_i, .sram_enable_in_n_i, .reset_o, .reset_n_o,
   .interrupt_n_o, .watchdog_timeout_flag_n_o, .reset_trip_level_n_o, .sram_enable_out_n_o, .supply_switch_flag_o
);

// [sim/sss_cpu_model.sv]
`timescale 1ns/1ps
module sss_cpu_model (
   // Clock.
   input  wire logic clk_sys_i,
   // Requests from the bench.
   input  wire logic kick_req_i,
   input  wire logic open_req_i,
   input  wire logic ce_req_n_i,
   // Pins toward the supervisor.
   output logic      watchdog_kick_n_o,
   output logic      watchdog_kick_open_o,
   output logic      sram_enable_in_n_o
);
   logic [1:0] low_cnt = 2'h0;
   initial begin
      watchdog_kick_open_o = 1'b0;
      sram_enable_in_n_o = 1'b1;
   end
   // A kick is a falling edge held low long enough to cross the synchroniser.
   always @(posedge clk_sys_i) begin
      watchdog_kick_open_o <= open_req_i;
      sram_enable_in_n_o <= ce_req_n_i;
      low_cnt <= kick_req_i ? 2'h3 : low_cnt - 2'(low_cnt != 2'h0);
   end
   assign watchdog_kick_n_o = (low_cnt == 2'h0);
endmodule // sss_cpu_model

// [sim/supply_supervisor_sequencer_tb.sv]
`timescale 1ns/1ps
module supply_supervisor_sequencer_tb;
   typedef struct packed {
      int         at;
      logic [7:0] mask;
      logic [7:0] val;
   } sss_note_t;
   localparam int PU = 60;
   logic                 clk_sys_i = 1'b0;
   logic                 sys_rst_i = 1'b1;
   sss_pkg::sss_supply_t supply    = 4'h1;
   logic                 tb_in     = 1'b1;
   logic                 tb_sel    = 1'b1;
   logic                 ext_run   = 1'b0;
   logic                 kick_req  = 1'b0;
   logic                 open_req  = 1'b0;
   logic                 ce_req    = 1'b1;
   wire                  kick_n;
   wire                  kick_open;
   wire                  ce_n;
   wire  [7:0]           outs;
   int                   n_mismatch = 0;
   int                   n_checks   = 0;
   int                   cyc        = 0;
   int                   t0;
   integer               seed       = 32'h889B;
   sss_note_t            notes[$];
   always #50 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (ext_run) tb_in <= ~tb_in;
   sss_supervisor #(.WD_LONG(200), .WD_SHORT(100), .RST_PULSE(50), .PU_RESET(PU)) u_dut (
      .clk_sys_i, .sys_rst_i, .supply_i(supply), .timebase_input_i(tb_in), .timebase_select_i(tb_sel),
      .watchdog_kick_n_i(kick_n), .watchdog_kick_open_i(kick_open), .reset_o(outs[7]), .reset_n_o(outs[6]),
      .interrupt_n_o(outs[5]), .watchdog_timeout_flag_n_o(outs[4]), .reset_trip_level_n_o(outs[3]),
      .sram_enable_in_n_i(ce_n), .sram_enable_out_n_o(outs[2]), .switched_sram_supply_o(outs[1]),
      .supply_switch_flag_o(outs[0]));
   sss_cpu_model u_cpu (.clk_sys_i, .kick_req_i(kick_req), .open_req_i(open_req), .ce_req_n_i(ce_req),
      .watchdog_kick_n_o(kick_n), .watchdog_kick_open_o(kick_open), .sram_enable_in_n_o(ce_n));
   task automatic final_report();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic note(input int d, input logic [7:0] mask, input logic [7:0] val);
      notes.push_back('{cyc + d, mask, val});
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t saw %b wanted %b", $time, seen, exp);
      end
   endtask
   task automatic wait_rst(input logic lvl, input int max);
      int i;
      for (i = 0; i < max && outs[7] !== lvl; i++) @(posedge clk_sys_i);
      if (i == max) begin
         n_mismatch++;
         final_report();
      end
   endtask
   task automatic gap(input logic lvl, input int exp);
      t0 = cyc;
      wait_rst(lvl, exp + 50);
      check(8'(cyc - t0 inside {[exp - 2:exp + 10]}), 8'h01);
   endtask
   task automatic kick();
      kick_req <= 1'b1;
      tick(1);
      kick_req <= 1'b0;
      tick(1);
   endtask
   // The watcher compares the oldest note when its cycle comes round.
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (notes.size() != 0 && notes[0].at == cyc) begin
         check(outs & notes[0].mask, notes[0].val);
         void'(notes.pop_front());
      end
   end
   initial begin
      tick(16);
      sys_rst_i <= 1'b0;
      note(50, 8'hC0, 8'h80);
      note(PU + 10, 8'hC6, 8'h46);
      wait_rst(1'b0, PU + 20);
      gap(1'b1, 200);
      note(5, 8'h90, 8'h80);
      gap(1'b0, 50);
      kick();
      note(8, 8'h10, 8'h10);
      repeat (12) begin
         repeat (20 + ($random(seed) & 32'h3F)) begin
            ce_req <= 1'($random(seed));
            tick(1);
         end
         kick();
      end
      note(2, 8'h80, 8'h00);
      ce_req <= 1'b1;
      tb_in <= 1'b0;
      kick();
      gap(1'b1, 100);
      gap(1'b0, 50);
      tb_in <= 1'b1;
      open_req <= 1'b1;
      note(8, 8'h10, 8'h10);
      note(300, 8'h80, 8'h00);
      tick(302);
      open_req <= 1'b0;
      kick();
      ce_req <= 1'b0;
      supply.below_sense_trip <= 1'b1;
      note(8, 8'h24, 8'h00);
      tick(10);
      supply.below_reset_trip <= 1'b1;
      note(8, 8'hDC, 8'h80);
      note(70, 8'h04, 8'h04);
      tick(72);
      supply.below_battery <= 1'b1;
      note(8, 8'h07, 8'h07);
      tick(10);
      supply.battery_present <= 1'b0;
      tick(10);
      supply.battery_present <= 1'b1;
      note(8, 8'h02, 8'h00);
      tick(10);
      supply.below_battery <= 1'b0;
      note(8, 8'h03, 8'h02);
      tick(10);
      supply.below_reset_trip <= 1'b0;
      supply.below_sense_trip <= 1'b0;
      note(PU - 10, 8'hA0, 8'hA0);
      note(PU + 10, 8'h80, 8'h00);
      tick(PU + 12);
      supply.below_reset_trip <= 1'b1;
      supply.below_battery <= 1'b1;
      tick(20);
      ce_req <= 1'b1;
      note(6, 8'h07, 8'h07);
      tick(10);
      ce_req <= 1'b0;
      note(20, 8'h04, 8'h04);
      tick(22);
      supply.below_reset_trip <= 1'b0;
      supply.below_battery <= 1'b0;
      tick(8);
      tb_sel <= 1'b0;
      ext_run <= 1'b1;
      sys_rst_i <= 1'b1;
      tick(16);
      sys_rst_i <= 1'b0;
      wait_rst(1'b0, PU + 20);
      gap(1'b1, 2 * sss_pkg::EXT_FIRST_CLKS);
      gap(1'b0, 2 * sss_pkg::EXT_RESET_CLKS);
      gap(1'b1, 2 * sss_pkg::EXT_NORMAL_CLKS);
      if (notes.size() != 0) n_mismatch++;
      final_report();
   end
endmodule // supply_supervisor_sequencer_tb
